// ==== dcrc_map.svh ====
`ifndef DCRC_MAP_SVH
`define DCRC_MAP_SVH

`define DCRC_POLY16        16'h1021
`define DCRC_POLY32        32'h04C11DB7
`define DCRC_INIT16        16'hFFFF
`define DCRC_INIT32        32'hFFFFFFFF
`define DCRC_CH_W          5
`define DCRC_BEAT_BYTE     2'h0
`define DCRC_BEAT_HALF     2'h1
`define DCRC_BEAT_WORD     2'h2
`define DCRC_SRC_APB       1'h0
`define DCRC_SRC_DMA       1'h1
`define DCRC_POLY_RST      1'h0

`endif

// ==== dcrc_pkg.sv ====
package dcrc_pkg;
  typedef enum logic [1:0] {
    DCRC_BEAT_8  = 2'h0,
    DCRC_BEAT_16 = 2'h1,
    DCRC_BEAT_32 = 2'h2
  } dcrc_beat_t;
  typedef enum logic [1:0] {
    DCRC_IDLE = 2'h0,
    DCRC_FEED = 2'h1
  } dcrc_state_t;
endpackage

// ==== dcrc_byte_if.sv ====
`timescale 1ns/1ns
interface dcrc_byte_if;
  logic        load;
  logic [31:0] load_val;
  logic        step;
  logic [7:0]  byte_data;
  logic        poly32;
  logic [31:0] crc;
  modport ctl (output load, output load_val, output step, output byte_data, output poly32,
               input crc);
  modport eng (input load, input load_val, input step, input byte_data, input poly32,
               output crc);
endinterface

// ==== dcrc_byte_eng.sv ====
`timescale 1ns/1ns
`include "dcrc_map.svh"
module dcrc_byte_eng
  import dcrc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // Byte stream
  dcrc_byte_if.eng  bi
);
  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  logic [31:0] x [0:8];
  logic [7:0]  fb;

  assign x[0] = crc_reg;
  // One bit per stage, MSB first; both widths run non-reflected
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign fb[g]  = bi.poly32 ? (x[g][31] ^ bi.byte_data[7-g])
                                : (x[g][15] ^ bi.byte_data[7-g]);
      assign x[g+1] = bi.poly32 ?
                      ({x[g][30:0], 1'b0} ^ (fb[g] ? `DCRC_POLY32 : 32'h0)) :
                      ({16'h0, x[g][14:0], 1'b0} ^ (fb[g] ? {16'h0, `DCRC_POLY16} : 32'h0));
    end
  endgenerate

  always_comb begin
    crc_next = crc_reg;
    if (bi.load)
      crc_next = bi.load_val;
    else if (bi.step)
      crc_next = x[8];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i)
      crc_reg <= {16'h0, `DCRC_INIT16};
    else
      crc_reg <= crc_next;
  end

  assign bi.crc = crc_reg;

  property p_load_takes;
    @(posedge mclk_i) disable iff (!rstn_i)
    bi.load |=> crc_reg == $past(bi.load_val);
  endproperty
  a_load_takes: assert property (p_load_takes)
    else $error("start value not loaded");
  property p_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    !bi.load && !bi.step |=> $stable(crc_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("checksum moved with no byte");
endmodule

// ==== dma_side_crc_engine.sv ====
`timescale 1ns/1ns
`include "dcrc_map.svh"
// Notes on behaviour
// - Offer 16-bit 0x1021 and 32-bit 0x04C11DB7
// - Source is DMA channel or bus writes
// - Running checksum readable in result register
// - 32-bit result reads reversed and inverted
// - Polynomial bit selects; reset picks 16-bit
// - Checksum advances one byte per step
// - DMA bytes per beat follow channel size
// - Bus write bytes folded one by one
module dma_side_crc_engine
  import dcrc_pkg::*;
#(
  parameter int CH_W = `DCRC_CH_W
)(
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  // Control settings
  input  wire logic            checksum_input_source_i,
  input  wire logic [CH_W-1:0] checksum_channel_i,
  input  wire logic            checksum_polynomial_type_i,
  input  wire logic [1:0]      checksum_bus_beat_width_i,
  // Bus writes of input words
  input  wire logic            input_word_wr_i,
  input  wire logic [31:0]     checksum_input_word_i,
  // Result register writes
  input  wire logic            result_wr_i,
  input  wire logic [31:0]     result_wdata_i,
  // DMA beats
  input  wire logic            dma_beat_valid_i,
  input  wire logic [CH_W-1:0] dma_beat_channel_i,
  input  wire logic [1:0]      dma_beat_size_i,
  input  wire logic [31:0]     dma_beat_data_i,
  // Status
  output logic                 busy_o,
  output logic                 input_ready_o,
  output logic [31:0]          checksum_result_o
);
  dcrc_byte_if bi ();

  dcrc_state_t state_reg;
  logic [31:0] word_reg;
  logic [1:0]  left_reg;
  logic        poly32_reg;
  logic        take;
  logic [31:0] take_data;
  logic [1:0]  take_size;
  logic        dma_hit;
  logic [31:0] rev;
  logic [31:0] wdata_rev;
  logic [31:0] shown;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  assign dma_hit = dma_beat_valid_i && (dma_beat_channel_i == checksum_channel_i);

  always_comb begin
    take      = 1'b0;
    take_data = checksum_input_word_i;
    take_size = checksum_bus_beat_width_i;
    if (checksum_input_source_i == `DCRC_SRC_DMA) begin
      take      = dma_hit;
      take_data = dma_beat_data_i;
      take_size = dma_beat_size_i;
    end else begin
      take = input_word_wr_i;
    end
  end

  // Input is refused while a beat is still being folded; sources must hold off
  assign input_ready_o = (state_reg == DCRC_IDLE) && !result_wr_i;
  assign busy_o        = (state_reg == DCRC_FEED);

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer: low byte first
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg <= DCRC_IDLE;
      word_reg  <= 32'h0;
      left_reg  <= 2'h0;
    end else begin
      case (state_reg)
        DCRC_IDLE: begin
          if (take && input_ready_o) begin
            word_reg <= take_data;
            if (take_size == `DCRC_BEAT_BYTE) begin
              left_reg <= 2'h0;
            end else begin
              left_reg  <= (take_size == `DCRC_BEAT_HALF) ? 2'h1 : 2'h3;
              state_reg <= DCRC_FEED;
            end
          end
        end
        DCRC_FEED: begin
          if (result_wr_i) begin
            state_reg <= DCRC_IDLE;
          end else begin
            word_reg <= {8'h0, word_reg[31:8]};
            left_reg <= left_reg - 2'h1;
            if (left_reg == 2'h1)
              state_reg <= DCRC_IDLE;
          end
        end
        default: state_reg <= DCRC_IDLE;
      endcase
    end
  end

  // Polynomial latched only on idle cycles, so it holds steady through the feed cycles of a beat
  always_ff @(posedge mclk_i) begin
    if (!rstn_i)
      poly32_reg <= `DCRC_POLY_RST;
    else if (state_reg == DCRC_IDLE)
      poly32_reg <= checksum_polynomial_type_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  assign bi.load      = result_wr_i;
  // Result write stores the visible form back in internal order
  assign bi.load_val  = poly32_reg ? ~wdata_rev : result_wdata_i;
  assign bi.poly32    = poly32_reg;
  assign bi.step      = (state_reg == DCRC_FEED) ? !result_wr_i : (take && input_ready_o);
  assign bi.byte_data = (state_reg == DCRC_FEED) ? word_reg[15:8] : take_data[7:0];

  dcrc_byte_eng u_eng (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .bi     (bi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result view
  genvar r;
  generate
    for (r = 0; r < 32; r++) begin : g_rev
      assign rev[r]       = bi.crc[31-r];
      assign wdata_rev[r] = result_wdata_i[31-r];
    end
  endgenerate
  assign shown = poly32_reg ? ~rev : {16'h0, bi.crc[15:0]};

  always_ff @(posedge mclk_i) begin
    if (!rstn_i)
      checksum_result_o <= {16'h0, `DCRC_INIT16};
    else
      checksum_result_o <= shown;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_poly;
    @(posedge mclk_i) $rose(rstn_i) |-> !poly32_reg;
  endproperty
  a_reset_poly: assert property (p_reset_poly)
    else $error("reset left 32-bit polynomial");
  property p_poly_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    busy_o |=> $stable(poly32_reg);
  endproperty
  a_poly_hold: assert property (p_poly_hold)
    else $error("polynomial changed inside a beat");
  // A result write during the tail aborts it, so only clean tails are checked
  property p_word_len;
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == DCRC_IDLE && take && input_ready_o && take_size == `DCRC_BEAT_WORD)
    ##1 !result_wr_i [*2] |-> busy_o ##1 busy_o ##1 !busy_o;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word beat not four bytes");
  property p_take_busy;
    @(posedge mclk_i) disable iff (!rstn_i)
    state_reg == DCRC_IDLE && take && input_ready_o && take_size != `DCRC_BEAT_BYTE
    |=> busy_o;
  endproperty
  a_take_busy: assert property (p_take_busy)
    else $error("multi-byte beat did not start folding");
  property p_half_len;
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == DCRC_IDLE && take && input_ready_o && take_size == `DCRC_BEAT_HALF)
    |=> busy_o ##1 !busy_o;
  endproperty
  a_half_len: assert property (p_half_len)
    else $error("half beat not two bytes");
  property p_byte_idle;
    @(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == DCRC_IDLE && take && input_ready_o && take_size == `DCRC_BEAT_BYTE)
    |=> !busy_o;
  endproperty
  a_byte_idle: assert property (p_byte_idle)
    else $error("byte beat left the engine busy");
  property p_view32;
    @(posedge mclk_i) disable iff (!rstn_i)
    poly32_reg && $stable(poly32_reg) |=> checksum_result_o == ~$past(rev)
      && checksum_result_o[0] == !$past(bi.crc[31]) && checksum_result_o[31] == !$past(bi.crc[0]);
  endproperty
  a_view32: assert property (p_view32)
    else $error("32-bit view wrong");
  property p_view16;
    @(posedge mclk_i) disable iff (!rstn_i)
    !poly32_reg |=> checksum_result_o[31:16] == 16'h0;
  endproperty
  a_view16: assert property (p_view16)
    else $error("16-bit view wide");
  property p_src_dma;
    @(posedge mclk_i) disable iff (!rstn_i)
    checksum_input_source_i && !dma_hit && !busy_o |-> !bi.step;
  endproperty
  a_src_dma: assert property (p_src_dma)
    else $error("byte taken from wrong source");
  property p_src_bus;
    @(posedge mclk_i) disable iff (!rstn_i)
    !checksum_input_source_i && !input_word_wr_i && !busy_o |-> !bi.step;
  endproperty
  a_src_bus: assert property (p_src_bus)
    else $error("byte taken without bus write");
  property p_one_step;
    @(posedge mclk_i) disable iff (!rstn_i)
    busy_o && !result_wr_i |-> bi.step;
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("feed cycle skipped a byte");
  // A written start value reads back while the polynomial holds; the 16-bit view keeps only its low half
  property p_rt32;
    @(posedge mclk_i) disable iff (!rstn_i)
    result_wr_i && poly32_reg ##1 poly32_reg
    |=> checksum_result_o == $past(result_wdata_i, 2);
  endproperty
  a_rt32: assert property (p_rt32)
    else $error("32-bit start value did not read back");
  property p_rt16;
    @(posedge mclk_i) disable iff (!rstn_i)
    result_wr_i && !poly32_reg ##1 !poly32_reg
    |=> checksum_result_o == {16'h0, $past(result_wdata_i[15:0], 2)};
  endproperty
  a_rt16: assert property (p_rt16)
    else $error("16-bit start value did not read back");
endmodule

// ==== dcrc_dma_model.sv ====
`timescale 1ns/1ns
module dcrc_dma_model (
  // Request from the bench, ready from the engine
  input  wire logic        mclk_i,
  input  wire logic        req_i,
  input  wire logic [38:0] beat_i,
  input  wire logic        ready_i,
  // Beat toward the engine
  output logic             valid_o,
  output logic [38:0]      beat_o
);
  initial {valid_o, beat_o} = '0;
  // Idle lines flip so a stale beat never looks valid
  always @(posedge mclk_i)
    if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      beat_o  <= ~beat_o;
    end else if (!valid_o && req_i) begin
      valid_o <= 1'b1;
      beat_o  <= beat_i;
    end
endmodule

// ==== test_dma_side_crc_engine.sv ====
`timescale 1ns/1ns
`include "dcrc_map.svh"
module test_dma_side_crc_engine;
  import dcrc_pkg::*;
  logic        mclk_i = 0, rstn_i = 0, src = 0, p32 = 0, wr = 0, rwr = 0;
  logic        req = 0, chk = 0, dv, busy, rdy;
  logic [1:0]  bw = 2'h0;
  logic [38:0] qb = '0, bo;
  logic [31:0] wd = '0, rwd = '0, res, st = 32'h0000FFFF, lf = 32'h945A;
  logic [31:0] q[$];
  int          fail_count = 0, comparisons = 0;
  //////////////////////////////////////////////////////////////////
  initial forever #5 mclk_i = ~mclk_i;
  dma_side_crc_engine DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .checksum_input_source_i(src),
    .checksum_channel_i(5'h3), .checksum_polynomial_type_i(p32),
    .checksum_bus_beat_width_i(bw), .input_word_wr_i(wr), .checksum_input_word_i(wd),
    .result_wr_i(rwr), .result_wdata_i(rwd), .dma_beat_valid_i(dv),
    .dma_beat_channel_i(bo[38:34]), .dma_beat_size_i(bo[33:32]), .dma_beat_data_i(bo[31:0]),
    .busy_o(busy), .input_ready_o(rdy), .checksum_result_o(res));
  dcrc_dma_model dma (.mclk_i(mclk_i), .req_i(req), .beat_i(qb), .ready_i(rdy),
    .valid_o(dv), .beat_o(bo));
  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      if (p32) c = {c[30:0], 1'b0} ^ (c[31] ^ b[i] ? `DCRC_POLY32 : 32'h0);
      else c = {16'h0, c[14:0], 1'b0} ^ (c[15] ^ b[i] ? 32'(`DCRC_POLY16) : 32'h0);
    return c;
  endfunction
  function automatic logic [31:0] vis(logic [31:0] c);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = c[31-i];
    return p32 ? ~r : {16'h0, c[15:0]};
  endfunction
  function automatic logic [31:0] nxt();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic guard(int n);
    if (n > 50) begin
      fail_count++;
      results();
    end
  endtask
  // Watcher takes the oldest note once the driver says the result stands
  always @(posedge mclk_i) if (chk) check("checksum_result", res, q.pop_front());
  task automatic note();
    repeat (2) @(posedge mclk_i);
    #1 q.push_back(vis(st));
    chk = 1;
    @(posedge mclk_i);
    #1 chk = 0;
  endtask
  task automatic beat(logic dma, logic [1:0] sz, logic [4:0] ch);
    logic [31:0] d;
    logic [31:0] nb;
    logic        hit;
    int          k;
    d = nxt();
    hit = !dma || ch == 5'h3;
    nb = !hit ? 32'h0 : sz == 2'h0 ? 32'h0 : sz == 2'h1 ? 32'h1 : 32'h3;
    if (dma) begin
      {req, qb} = {1'b1, ch, sz, d};
      @(posedge mclk_i);
      #1 req = 0;
      for (int n = 0; dv !== 1'b0; n++) begin
        @(posedge mclk_i);
        #1 guard(n);
      end
    end else begin
      {wr, wd, bw} = {1'b1, d, sz};
      @(posedge mclk_i);
      #1 wr = 0;
    end
    if (hit)
      for (int i = 0; i < (sz == 0 ? 1 : sz == 1 ? 2 : 4); i++) st = fold(st, d[8*i+:8]);
    // Half and word beats need busy to drop before the next request
    for (k = 0; busy !== 1'b0; k++) begin
      @(posedge mclk_i);
      #1 guard(k);
    end
    check("busy_cycles", 32'(k), nb);
    check("input_ready_o", {31'h0, rdy}, 32'h1);
    note();
  endtask
  task automatic wres(logic [31:0] v, logic [31:0] s);
    {rwr, rwd} = {1'b1, v};
    @(posedge mclk_i);
    #1 rwr = 0;
    st = s;
    note();
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk_i);
    #1 rstn_i = 1;
    note();
    for (int i = 0; i < 12; i++) beat(0, 2'(i % 3), 5'h0);
    $display("bus crc16 test done");
    wres(32'h0000ABCD, 32'h0000ABCD);
    beat(0, 2'h2, 5'h0);
    p32 = 1;
    // The polynomial bit is latched on an idle edge before the start value
    @(posedge mclk_i);
    #1 wres(32'h0, `DCRC_INIT32);
    for (int i = 0; i < 6; i++) beat(0, 2'(i % 3), 5'h0);
    $display("bus crc32 test done");
    src = 1;
    for (int i = 0; i < 9; i++) beat(1, 2'(i % 3), i == 4 ? 5'h7 : 5'h3);
    $display("dma test done");
    results();
  end
endmodule
